//--- src/vpan_top.sv
// vpan_top: virtual phy register bank with emulated negotiation
// assumes an APB master on clk and static pins for duplex and straps
`timescale 1ns/1ps
module vpan_top #(
    parameter int SOFT_RST_CYCLES = vpan_pkg::SOFT_RST_CYCLES
) (
    // clock, reset and enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    // static pins and straps
    input wire logic port0DuplexPin,
    input wire logic port0DuplexPolarityStrap,
    input wire logic port0SpeedStrap,
    input wire logic macMode,
    // port 0 mac configuration
    output vpan_pkg::vpan_cfg_t port0Cfg_q
);
    localparam logic [14:0] RST_CNT_LOAD = 15'(SOFT_RST_CYCLES);

    // ********************
    // pins and straps
    // ********************
    logic [3:0] pinSync;
    logic [2:0] strapCap_q;
    logic [2:0] settle_q;
    logic strapsReady_q;

    vpan_pin_sync #(.WIDTH(4)) u_pinSync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .pinIn({macMode, port0SpeedStrap, port0DuplexPolarityStrap, port0DuplexPin}),
        .pinOut_q(pinSync)
    );

    // ********************
    // state
    // ********************
    logic [15:0] ctrl_q;
    logic [15:0] adv_q;
    logic [3:0] lpTech_q;
    logic [1:0] lpPause_q;
    logic lpAble_q;
    logic pageRx_q;
    logic anDone_q;
    logic pending_q;
    logic digRst_q;
    logic reload_q;
    logic [14:0] vphyCnt_q;
    vpan_pkg::vpan_neg_state_t state_q;
    vpan_pkg::vpan_neg_state_t state_d;
    vpan_pkg::vpan_cfg_t neg_q;

    // ********************
    // apb decode
    // ********************
    logic wrEn, rdLoad, selCtrl, selStat, selId1, selId2, selAdv, selLp, selExp, selChip;
    logic wrCtrl, wrAdv, wrChip, restartReq;
    logic [31:0] rdWord;

    // access phase, write lands on the edge that sees pready
    assign wrEn = psel & penable & pready_q & pwrite;
    assign rdLoad = psel & penable & ~pready_q & ~pwrite;
    assign selCtrl = paddr == vpan_pkg::VIRTUAL_BASIC_CONTROL_REG_OFF;
    assign selStat = paddr == vpan_pkg::VIRTUAL_BASIC_STATUS_REG_OFF;
    assign selId1 = paddr == vpan_pkg::PHY_ID1_REG_OFF;
    assign selId2 = paddr == vpan_pkg::PHY_ID2_REG_OFF;
    assign selAdv = paddr == vpan_pkg::LOCAL_ADVERTISEMENT_REG_OFF;
    assign selLp = paddr == vpan_pkg::PARTNER_ABILITY_REG_OFF;
    assign selExp = paddr == vpan_pkg::NEGOTIATION_EXPANSION_REG_OFF;
    assign selChip = paddr == vpan_pkg::CHIP_RESET_CONTROL_REG_OFF;
    assign wrCtrl = wrEn & selCtrl;
    assign wrAdv = wrEn & selAdv;
    assign wrChip = wrEn & selChip;
    assign restartReq = wrCtrl & pwdata[vpan_pkg::CTRL_RESTART_POS];

    // read mux, unmapped words read as all ones in the low half
    assign rdWord = selCtrl ? {16'h0000, ctrl_q} :
        selStat ? {16'h0000, vpan_pkg::STATUS_FIXED[15:6], anDone_q,
            vpan_pkg::STATUS_FIXED[4:0]} :
        selId1 ? {16'h0000, vpan_pkg::PHY_ID1_VALUE} :
        selId2 ? {16'h0000, vpan_pkg::PHY_ID2_VALUE} :
        selAdv ? {16'h0000, adv_q} :
        selLp ? {20'h00000, lpPause_q, 1'b0, lpTech_q, vpan_pkg::LP_SELECTOR} :
        selExp ? {30'h0000000, pageRx_q, lpAble_q} :
        selChip ? {29'h0000000, reload_q, vphyCnt_q != 15'h0000, digRst_q} :
        vpan_pkg::UNMAPPED_READ;

    // one wait state, data and ready from flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            pready_q <= psel & penable & ~pready_q;
            if (rdLoad) begin
                prdata_q <= rdWord;
            end
        end
    end

    // ********************
    // resets and restart sources
    // ********************
    logic bankReset, anEn, start;

    assign anEn = ctrl_q[vpan_pkg::CTRL_AN_EN_POS];
    assign bankReset = ctrl_q[vpan_pkg::CTRL_SOFT_RESET_POS] | digRst_q | reload_q
        | (vphyCnt_q != 15'h0000);
    assign start = (state_q == vpan_pkg::NEG_IDLE) & pending_q & anEn & strapsReady_q
        & ~bankReset;

    // chip reset control: one-cycle digital reset and reload, timed soft reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            digRst_q <= 1'b0;
            reload_q <= 1'b0;
            vphyCnt_q <= 15'h0000;
        end else if (ce) begin
            digRst_q <= wrChip & pwdata[vpan_pkg::CHIP_DIGITAL_POS];
            reload_q <= wrChip & pwdata[vpan_pkg::CHIP_RELOAD_POS];
            if (wrChip & pwdata[vpan_pkg::CHIP_VPHY_POS]) begin
                vphyCnt_q <= RST_CNT_LOAD;
            end else if (vphyCnt_q != 15'h0000) begin
                vphyCnt_q <= vphyCnt_q - 15'h0001;
            end
        end
    end

    // pending restart, set wins over the clear at start
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending_q <= 1'b1;
        end else if (ce) begin
            pending_q <= bankReset | restartReq | (pending_q & ~start);
        end
    end

    // straps caught once settled after reset and on reload only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            settle_q <= vpan_pkg::STRAP_SETTLE_CYCLES;
            strapCap_q <= 3'h0;
            strapsReady_q <= 1'b0;
        end else if (ce) begin
            if (reload_q) begin
                settle_q <= vpan_pkg::STRAP_SETTLE_CYCLES;
                strapsReady_q <= 1'b0;
            end else if (settle_q != 3'h0) begin
                settle_q <= settle_q - 3'h1;
                if (settle_q == 3'h1) begin
                    strapCap_q <= pinSync[2:0];
                    strapsReady_q <= 1'b1;
                end
            end
        end
    end

    // ********************
    // control and advertisement registers
    // ********************
    // soft reset bit clears itself one cycle after it is set
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= vpan_pkg::CTRL_RST;
        end else if (ce) begin
            if (bankReset) begin
                ctrl_q <= vpan_pkg::CTRL_RST;
            end else if (wrCtrl) begin
                ctrl_q <= pwdata[15:0] & vpan_pkg::CTRL_WMASK;
            end else if (start | ~anEn) begin
                ctrl_q[vpan_pkg::CTRL_RESTART_POS] <= 1'b0;
            end
        end
    end

    // writable pause and ability bits, selector fixed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            adv_q <= vpan_pkg::ADV_RST;
        end else if (ce) begin
            if (bankReset) begin
                adv_q <= vpan_pkg::ADV_RST;
            end else if (wrAdv) begin
                adv_q <= (pwdata[15:0] & vpan_pkg::ADV_WMASK) | vpan_pkg::ADV_SELECTOR;
            end
        end
    end

    // ********************
    // emulated partner and best common mode
    // ********************
    logic capFull, capSpeed;
    logic [3:0] advTech, partnerTech, common, pdTech;
    logic anyCommon, best100, bestFull;
    vpan_pkg::vpan_cfg_t negNext;

    assign capFull = strapCap_q[0] == strapCap_q[1];
    assign capSpeed = strapCap_q[2];
    assign advTech = adv_q[8:5];
    // partner offers both duplexes at full, half only otherwise
    assign partnerTech = capSpeed ?
        (capFull ? (vpan_pkg::TECH_100FD | vpan_pkg::TECH_100HD) : vpan_pkg::TECH_100HD) :
        (capFull ? (vpan_pkg::TECH_10FD | vpan_pkg::TECH_10HD) : vpan_pkg::TECH_10HD);
    assign common = advTech & partnerTech;
    assign anyCommon = common != 4'h0;
    assign best100 = common[3] | common[2];
    assign bestFull = common[3] | (~common[2] & common[1]);
    assign pdTech = capSpeed ? vpan_pkg::TECH_100HD : vpan_pkg::TECH_10HD;
    // failed negotiation falls back to strap speed at half duplex
    assign negNext = anyCommon ? {best100, bestFull, adv_q[10], adv_q[11]} :
        {capSpeed, 1'b0, 1'b0, 1'b0};

    // ********************
    // negotiation sequence
    // ********************
    // idle, complete, page received, result
    always_comb begin
        state_d = state_q;
        case (state_q)
            vpan_pkg::NEG_IDLE: begin
                if (start) begin
                    state_d = vpan_pkg::NEG_COMPLETE;
                end
            end
            vpan_pkg::NEG_COMPLETE: state_d = vpan_pkg::NEG_PAGE;
            vpan_pkg::NEG_PAGE: state_d = vpan_pkg::NEG_RESULT;
            default: state_d = vpan_pkg::NEG_IDLE;
        endcase
        if (bankReset) begin
            state_d = vpan_pkg::NEG_IDLE;
        end
    end

    // step flags and registered result
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= vpan_pkg::NEG_IDLE;
            anDone_q <= 1'b0;
            pageRx_q <= 1'b0;
            lpTech_q <= 4'h0;
            lpPause_q <= 2'h0;
            lpAble_q <= 1'b0;
            neg_q <= vpan_pkg::CFG_RST;
        end else if (ce) begin
            state_q <= state_d;
            if (bankReset | start) begin
                anDone_q <= 1'b0;
                pageRx_q <= 1'b0;
            end else if (state_q == vpan_pkg::NEG_COMPLETE) begin
                anDone_q <= 1'b1;
            end else if (state_q == vpan_pkg::NEG_PAGE) begin
                pageRx_q <= 1'b1;
            end
            if (bankReset) begin
                lpTech_q <= 4'h0;
                lpPause_q <= 2'h0;
                lpAble_q <= 1'b0;
            end else if (state_q == vpan_pkg::NEG_RESULT) begin
                lpTech_q <= anyCommon ? partnerTech : pdTech;
                lpPause_q <= anyCommon ? adv_q[11:10] : 2'h0;
                lpAble_q <= anyCommon;
                neg_q <= negNext;
            end
        end
    end

    // ********************
    // port 0 configuration
    // ********************
    logic liveFull;
    vpan_pkg::vpan_cfg_t cfgNext;

    assign liveFull = pinSync[0] == pinSync[1];
    assign cfgNext = ~anEn ? {ctrl_q[vpan_pkg::CTRL_SPEED_POS],
            ctrl_q[vpan_pkg::CTRL_DUPLEX_POS], 1'b0, 1'b0} :
        pinSync[3] ? {neg_q.speed100, liveFull, neg_q.pauseSym, neg_q.pauseAsym} :
        neg_q;

    // applied to the fabric mac every enabled cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port0Cfg_q <= vpan_pkg::CFG_RST;
        end else if (ce) begin
            port0Cfg_q <= cfgNext;
        end
    end

    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !ce);

    restart_self_clear_a: assert property (start && !wrCtrl |=>
        !ctrl_q[vpan_pkg::CTRL_RESTART_POS]) else $error("restart bit not cleared");
    step_order_a: assert property (state_q == vpan_pkg::NEG_COMPLETE && !bankReset
        |=> anDone_q && !pageRx_q && state_q == vpan_pkg::NEG_PAGE)
        else $error("negotiation steps out of order");
    restart_runs_a: assert property (restartReq && pwdata[vpan_pkg::CTRL_AN_EN_POS]
        && !pwdata[vpan_pkg::CTRL_SOFT_RESET_POS] && strapsReady_q && !bankReset
        && state_q == vpan_pkg::NEG_IDLE |-> ##[1:2] state_q == vpan_pkg::NEG_COMPLETE)
        else $error("restart did not start negotiation");
    top_priority_a: assert property (state_q == vpan_pkg::NEG_RESULT && !bankReset
        && common[3] |=> neg_q.speed100 && neg_q.fullDuplex)
        else $error("100 full not chosen");
    success_load_a: assert property (state_q == vpan_pkg::NEG_RESULT && !bankReset
        && anyCommon |=> lpAble_q && lpTech_q == $past(partnerTech))
        else $error("partner abilities not loaded");
    parallel_half_a: assert property (state_q == vpan_pkg::NEG_RESULT && !bankReset
        && !anyCommon |=> !lpAble_q && !neg_q.fullDuplex && neg_q.speed100 == strapCap_q[2]
        && $onehot(lpTech_q)) else $error("parallel detection result wrong");
    adv_default_a: assert property (bankReset |=> adv_q[8:5] == 4'hF)
        else $error("advertisement not reset to all abilities");
    no_t4_np_a: assert property (adv_q[15:12] == 4'h0 && !adv_q[9])
        else $error("forbidden advertisement bit set");
    result_hold_a: assert property (state_q != vpan_pkg::NEG_RESULT |=> $stable(neg_q))
        else $error("result changed outside negotiation");
    forced_mode_a: assert property (!anEn ##1 1'b1 |->
        port0Cfg_q.speed100 == $past(ctrl_q[vpan_pkg::CTRL_SPEED_POS])
        && port0Cfg_q.fullDuplex == $past(ctrl_q[vpan_pkg::CTRL_DUPLEX_POS]))
        else $error("forced speed or duplex not applied");
    mac_duplex_a: assert property (anEn && pinSync[3] |=>
        port0Cfg_q.fullDuplex == $past(liveFull)) else $error("mac mode duplex wrong");

    neg_success_c: cover property (state_q == vpan_pkg::NEG_RESULT && anyCommon);
    neg_parallel_c: cover property (state_q == vpan_pkg::NEG_RESULT && !anyCommon);
    forced_mode_c: cover property (!anEn && port0Cfg_q.speed100);
    mac_mode_c: cover property (anEn && pinSync[3] && !liveFull);
endmodule // vpan_top

//--- src/vpan_pkg.sv
// vpan_pkg: offsets, fields, reset values and types of the virtual phy bank
// assumes a 250 MHz system clock and an APB bus with 32-bit data
package vpan_pkg;
    // ********************
    // timing
    // ********************
    localparam int CLK_PERIOD_NS = 4;
    localparam int SOFT_RST_TIME_NS = 102000;
    localparam int SOFT_RST_CYCLES = (SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h5;
    // ********************
    // register offsets
    // ********************
    localparam logic [7:0] VIRTUAL_BASIC_CONTROL_REG_OFF = 8'h00;
    localparam logic [7:0] VIRTUAL_BASIC_STATUS_REG_OFF = 8'h04;
    localparam logic [7:0] PHY_ID1_REG_OFF = 8'h08;
    localparam logic [7:0] PHY_ID2_REG_OFF = 8'h0C;
    localparam logic [7:0] LOCAL_ADVERTISEMENT_REG_OFF = 8'h10;
    localparam logic [7:0] PARTNER_ABILITY_REG_OFF = 8'h14;
    localparam logic [7:0] NEGOTIATION_EXPANSION_REG_OFF = 8'h18;
    localparam logic [7:0] CHIP_RESET_CONTROL_REG_OFF = 8'h40;
    // ********************
    // fields and reset values
    // ********************
    localparam int CTRL_SOFT_RESET_POS = 15;
    localparam int CTRL_SPEED_POS = 13;
    localparam int CTRL_AN_EN_POS = 12;
    localparam int CTRL_RESTART_POS = 9;
    localparam int CTRL_DUPLEX_POS = 8;
    localparam logic [15:0] CTRL_RST = 16'h3100;
    localparam logic [15:0] CTRL_WMASK = 16'hFF80;
    localparam logic [15:0] STATUS_FIXED = 16'h780D;
    localparam logic [15:0] ADV_RST = 16'h01E1;
    localparam logic [15:0] ADV_WMASK = 16'h0DE0;
    localparam logic [15:0] ADV_SELECTOR = 16'h0001;
    localparam logic [4:0] LP_SELECTOR = 5'h01;
    localparam int CHIP_DIGITAL_POS = 0;
    localparam int CHIP_VPHY_POS = 1;
    localparam int CHIP_RELOAD_POS = 2;
    // identity values are arbitrary
    localparam logic [15:0] PHY_ID1_VALUE = 16'h1234;
    localparam logic [15:0] PHY_ID2_VALUE = 16'h5670;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000FFFF;
    // technology bits, order 100FD 100HD 10FD 10HD
    localparam logic [3:0] TECH_100FD = 4'h8;
    localparam logic [3:0] TECH_100HD = 4'h4;
    localparam logic [3:0] TECH_10FD = 4'h2;
    localparam logic [3:0] TECH_10HD = 4'h1;
    // ********************
    // types
    // ********************
    typedef enum logic [1:0] {
        NEG_IDLE = 2'h0,
        NEG_COMPLETE = 2'h1,
        NEG_PAGE = 2'h3,
        NEG_RESULT = 2'h2
    } vpan_neg_state_t;
    typedef struct packed {
        logic speed100;
        logic fullDuplex;
        logic pauseSym;
        logic pauseAsym;
    } vpan_cfg_t;
    localparam vpan_cfg_t CFG_RST = 4'h0;
endpackage

//--- src/vpan_pin_sync.sv
// vpan_pin_sync: three-stage synchroniser for static pins and straps
// assumes inputs from outside the clock domain; a change counts once
// the second and third stages agree
`timescale 1ns/1ps
module vpan_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock, reset and enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // raw pins
    input wire logic [WIDTH-1:0] pinIn,
    // agreed value
    output logic [WIDTH-1:0] pinOut_q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] agree;

    // bits whose last two stages match
    assign agree = ~(s2_q ^ s3_q);

    // shift chain and filtered output
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pinOut_q <= '0;
        end else if (ce) begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pinOut_q <= (s3_q & agree) | (pinOut_q & ~agree);
        end
    end
endmodule // vpan_pin_sync

//--- sim/vpan_strap_model.sv
// vpan_strap_model: board straps and the external duplex indication
// assumes the bench sets the wanted levels; pins move only after a clock edge
`timescale 1ns/1ps
module vpan_strap_model (
    // clock
    input wire logic clk,
    // wanted levels: duplex pin, polarity strap, speed strap, mac mode
    input wire logic [3:0] pinReq,
    // levels at the bank
    output logic [3:0] pinOut
);
    // levels stay static between bench changes
    always_ff @(posedge clk) begin
        pinOut <= pinReq;
    end
endmodule // vpan_strap_model

//--- sim/vpan_top_tb.sv
// vpan_top_tb: register level bench for the virtual phy bank
// assumes vpan_top with an apb slave and the strap model beside it
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module vpan_top_tb;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata_q;
    logic pready_q, pslverr_q;
    logic [3:0] pinReq = 4'h2, pinOut;
    vpan_pkg::vpan_cfg_t port0Cfg_q;
    int err_total = 0, comparisons = 0;
    logic [7:0] rAddr [3] = '{8'h00, 8'h40, 8'h40};
    logic [15:0] rData [3] = '{16'h8000, 16'h0001, 16'h0002};
    logic [15:0] fCtl [3] = '{16'h2100, 16'h4580, 16'h2000};
    logic [3:0] fCfg [3] = '{4'hC, 4'h4, 4'h8};

    // 250 MHz clock
    always #2 clk = ~clk;

    vpan_strap_model u_straps (.clk(clk), .pinReq(pinReq), .pinOut(pinOut));

    vpan_top #(.SOFT_RST_CYCLES(8)) u_dut (
        .clk(clk), .reset(reset), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .port0DuplexPin(pinOut[3]), .port0DuplexPolarityStrap(pinOut[2]),
        .port0SpeedStrap(pinOut[1]), .macMode(pinOut[0]), .port0Cfg_q(port0Cfg_q)
    );

    // ********************
    // bus tasks
    // ********************
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready_q !== 1'b1 && n < 50);
        r = prdata_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            err_total++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] r;
        apb(1'b0, a, 32'h00000000, r);
        `CHK(r & m, e)
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic conclude();
        $display("TB: comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ********************
    // test sequence
    // ********************
    initial begin
        cyc(2);
        reset <= 1'b0;
        cyc(30);
        // defaults: straps offer 100 full and half
        rdc(8'h00, 32'h00003100, ALL);
        rdc(8'h10, 32'h000001E1, ALL);
        rdc(8'h3C, 32'h0000FFFF, ALL);
        `CHK(pslverr_q, 1'b0)
        rdc(8'h08, {16'h0000, vpan_pkg::PHY_ID1_VALUE}, ALL);
        rdc(8'h0C, {16'h0000, vpan_pkg::PHY_ID2_VALUE}, ALL);
        rdc(8'h04, 32'h0000782D, ALL);
        rdc(8'h18, 32'h00000003, ALL);
        rdc(8'h14, 32'h00000181, ALL);
        `CHK(port0Cfg_q, 4'hC)
        $display("TB: test defaults done");
        // late advertisement write, then restart with no common mode
        wr(8'h10, 32'h00000C61);
        cyc(20);
        `CHK(port0Cfg_q, 4'hC)
        wr(8'h00, 32'h00001200);
        rdc(8'h00, 32'h00001000, ALL);
        cyc(20);
        rdc(8'h18, 32'h00000002, ALL);
        rdc(8'h14, 32'h00000080, 32'h000001E0);
        `CHK(port0Cfg_q, 4'h8)
        $display("TB: test parallel detect done");
        // pause granted by the partner
        wr(8'h10, 32'h00000DE1);
        wr(8'h00, 32'h00001200);
        cyc(20);
        rdc(8'h14, 32'h00000D80, 32'h00000DE0);
        `CHK(port0Cfg_q, 4'hF)
        $display("TB: test pause done");
        // strap change alone, then reload: partner offers 10 half only
        pinReq <= 4'h8;
        cyc(20);
        `CHK(port0Cfg_q, 4'hF)
        wr(8'h40, 32'h00000004);
        cyc(40);
        rdc(8'h14, 32'h00000020, 32'h000001E0);
        `CHK(port0Cfg_q[3:2], 2'b00)
        $display("TB: test reload done");
        // soft, digital and bank resets rerun negotiation
        for (int i = 0; i < 3; i++) begin
            wr(8'h10, 32'h00000061);
            wr(rAddr[i], {16'h0000, rData[i]});
            if (i == 2) rdc(8'h40, 32'h00000002, 32'h00000002);
            cyc(40);
            rdc(8'h00, 32'h00003100, ALL);
            rdc(8'h10, 32'h000001E1, ALL);
            rdc(8'h04, 32'h0000782D, ALL);
            rdc(8'h18, 32'h00000003, ALL);
        end
        $display("TB: test resets done");
        // forced speed and duplex, stored-only control bits read back
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, {16'h0000, fCtl[i]});
            cyc(5);
            `CHK(port0Cfg_q, fCfg[i])
            rdc(8'h00, {16'h0000, fCtl[i]}, ALL);
        end
        $display("TB: test forced done");
        // mac mode: duplex follows pin against polarity strap
        pinReq <= 4'h9;
        wr(8'h00, 32'h00001000);
        cyc(10);
        `CHK(port0Cfg_q.fullDuplex, 1'b0)
        // enable low freezes the bank, the pin change waits for it
        ce <= 1'b0;
        pinReq <= 4'h1;
        cyc(10);
        `CHK(port0Cfg_q.fullDuplex, 1'b0)
        ce <= 1'b1;
        cyc(10);
        `CHK(port0Cfg_q.fullDuplex, 1'b1)
        $display("TB: test mac mode done");
        conclude();
    end
endmodule // vpan_top_tb
